// ---- rtl/rbx_exec.v ----
// How it works
// - opcode E7 branches when the negative flag is clear
// - opcode E5 branches when the overflow flag is clear
// - opcode E1 branches when the zero flag is clear
// - top bits 11010 form an unconditional branch, eleven-bit offset
// - taken target is incremented pc plus twice the offset
// - conditional offsets -128..127; one cycle untaken, two taken
// - unconditional offsets -1024..1023, always two cycles
// - taken: decode, read literal, compute, write pc; then idle cycle
// - set-bit opcode 1000 forces the selected bit, keeps others
// - set-bit: read in Q2, modify Q3, write back Q4
// - bank flag 0 uses access bank, 1 uses bank select register
// - skip-if-set discards the next instruction when tested bit is one
// - all these instructions take one word, no status changes
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "rbx_defs.vh"
module rbx_exec #(
   parameter PCW = 21
) (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // core view
   output reg  [PCW-1:0] pcOut,
   output reg  [3:0]     phaseOut
);
   // one-hot quarter phases of an instruction cycle
   localparam Q1 = 4'b0001;
   localparam Q2 = 4'b0010;
   localparam Q3 = 4'b0100;
   localparam Q4 = 4'b1000;

   reg  [3:0]     phase_r;
   reg            run_r;
   reg  [2:0]     flags_r;
   reg  [PCW-1:0] pc_r;
   reg  [15:0]    instr_r;
   reg  [15:0]    ir_r;
   reg            instrValid_r;
   reg  [3:0]     bank_r;
   reg  [11:0]    fileAddr_r;
   reg  [7:0]     modData_r;
   reg            nop_r;
   reg            skip_r;
   reg            take_r;
   reg            busy_r;
   reg  [10:0]    lit_r;
   reg            longForm_r;
   reg  [PCW-1:0] target_r;
   reg            hit;
   reg  [31:0]    rdMux;

   wire [PCW-1:0] target;
   wire           isSignBr;
   wire           isOvfBr;
   wire           isZeroBr;
   wire           isAlwaysBr;
   wire           isSetBit;
   wire           isBtss;
   wire           condSign;
   wire           condOvf;
   wire           condZero;
   wire           condOk;
   wire [11:0]    accessAddr;
   wire [11:0]    bankAddr;
   wire [11:0]    effAddr;
   wire [7:0]     rdData;
   wire [7:0]     bitMask;
   wire           skipHit;
   wire           apbWr;
   wire           bitSetWr;
   wire           swFileWr;
   wire [127:0]   fileFlat;
   genvar         g;

   assign isSignBr   = ir_r[15:8] == `RBX_OP_SIGN_BR;
   assign isOvfBr    = ir_r[15:8] == `RBX_OP_OVF_BR;
   assign isZeroBr   = ir_r[15:8] == `RBX_OP_ZERO_BR;
   assign isAlwaysBr = ir_r[15:11] == `RBX_OP_ALWAYS_BR;
   assign isSetBit   = ir_r[15:12] == `RBX_OP_SET_BIT;
   assign isBtss     = ir_r[15:12] == `RBX_OP_BTSS;

   // conditional opcodes branch only on a clear flag; the unconditional form always branches
   assign condSign = isSignBr & ~flags_r[`RBX_ST_NEG];
   assign condOvf  = isOvfBr & ~flags_r[`RBX_ST_OVF];
   assign condZero = isZeroBr & ~flags_r[`RBX_ST_ZERO];
   assign condOk   = condSign | condOvf | condZero | isAlwaysBr;

   assign accessAddr = {{4{ir_r[7]}}, ir_r[7:0]};
   assign bankAddr   = {bank_r, ir_r[7:0]};
   assign effAddr    = ir_r[8] ? bankAddr : accessAddr;
   // small file model: low four address bits select a storage byte
   assign rdData   = fileFlat[{effAddr[3:0], 3'b000} +: 8];
   assign bitMask  = 8'h01 << ir_r[11:9];
   assign skipHit  = isBtss && ((rdData & bitMask) != 8'h00);
   assign apbWr    = psel & penable & pwrite;
   assign bitSetWr = (phase_r == Q4) && isSetBit;
   assign swFileWr = apbWr && (paddr == `RBX_FDATA_OFF);

   // unmapped offsets answer with an error
   always @* begin
      case (paddr)
         `RBX_CTRL_OFF,
         `RBX_STATUS_OFF,
         `RBX_PC_OFF,
         `RBX_INSTR_OFF,
         `RBX_BANK_OFF,
         `RBX_FILE_OFF,
         `RBX_FDATA_OFF: hit = 1'b1;
         default:        hit = 1'b0;
      endcase
   end

   // read mux, registered below so prdata stands in the access phase
   always @* begin
      rdMux = 32'h0000_0000;
      case (paddr)
         `RBX_CTRL_OFF:   rdMux = {31'h0000_0000, run_r};
         `RBX_STATUS_OFF: rdMux = {16'h0000, phase_r, 2'b00, skip_r, busy_r, 5'h00, flags_r};
         `RBX_PC_OFF:     rdMux = {{(32-PCW){1'b0}}, pc_r};
         `RBX_INSTR_OFF:  rdMux = {16'h0000, instr_r};
         `RBX_BANK_OFF:   rdMux = {28'h000_0000, bank_r};
         `RBX_FILE_OFF:   rdMux = {20'h0_0000, fileAddr_r};
         `RBX_FDATA_OFF:  rdMux = {24'h00_0000, fileFlat[{fileAddr_r[3:0], 3'b000} +: 8]};
         default:         rdMux = 32'h0000_0000;
      endcase
   end

   rbx_target #(
      .PCW(PCW)
   ) uTarget (
      .pcInc   (pc_r),
      .offset  (lit_r),
      .longForm(longForm_r),
      .target  (target)
   );

   // quarter-phase sequencer, holds in Q1 while stopped
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_r <= Q1;
      end else begin
         case (phase_r)
            // stops only at an instruction boundary
            Q1: phase_r <= run_r ? Q2 : Q1;
            Q2: phase_r <= Q3;
            Q3: phase_r <= Q4;
            Q4: phase_r <= Q1;
            default: phase_r <= Q1;
         endcase
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pc_r         <= `RBX_PC_RST;
         ir_r         <= 16'h0000;
         nop_r        <= 1'b0;
         skip_r       <= 1'b0;
         take_r       <= 1'b0;
         busy_r       <= 1'b0;
         lit_r        <= 11'h000;
         longForm_r   <= 1'b0;
         target_r     <= `RBX_PC_RST;
         modData_r    <= 8'h00;
      end else begin
         case (phase_r)
            Q1: if (run_r) begin
               busy_r <= 1'b1;
               // flush cycle after a taken branch
               if (nop_r | skip_r | ~instrValid_r) begin
                  ir_r <= 16'h0000;
               end else begin
                  ir_r <= instr_r;
               end
               nop_r        <= 1'b0;
               skip_r       <= 1'b0;
               take_r       <= 1'b0;
               // single word, pc advances by two
               pc_r         <= pc_r + 2'd2;
            end
            Q2: begin
               // literal read, short or long offset
               lit_r      <= ir_r[10:0];
               longForm_r <= isAlwaysBr;
               modData_r  <= rdData;
            end
            Q3: begin
               // registered so the Q4 pc write sees a settled sum
               target_r  <= target;
               take_r    <= condOk;
               modData_r <= modData_r | bitMask;
            end
            Q4: begin
               busy_r <= 1'b0;
               if (take_r) begin
                  pc_r  <= target_r;
                  nop_r <= 1'b1;
               end
               // skip when tested bit is one
               if (skipHit) begin
                  skip_r <= 1'b1;
               end
            end
            default: busy_r <= 1'b0;
         endcase
      end
   end

   // instruction word valid; a write in the consuming Q1 wins
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         instrValid_r <= 1'b0;
      end else if (apbWr && paddr == `RBX_INSTR_OFF) begin
         instrValid_r <= 1'b1;
      end else if (phase_r == Q1 && run_r) begin
         instrValid_r <= 1'b0;
      end
   end

   // one byte register per entry; a set-bit write back wins over software
   generate
      for (g = 0; g < 16; g = g + 1) begin : gFile
         localparam [3:0] IDX = g;
         reg [7:0] byte_r;
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               byte_r <= 8'h00;
            end else if (bitSetWr && effAddr[3:0] == IDX) begin
               byte_r <= modData_r;
            end else if (swFileWr && fileAddr_r[3:0] == IDX) begin
               byte_r <= pwdata[7:0];
            end
         end
         assign fileFlat[g*8 +: 8] = byte_r;
      end
   endgenerate

   // apb registers; flags only ever change by software
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         run_r      <= 1'b0;
         flags_r    <= 3'b000;
         instr_r    <= 16'h0000;
         bank_r     <= 4'h0;
         fileAddr_r <= 12'h000;
      end else if (apbWr) begin
         case (paddr)
            `RBX_CTRL_OFF:   run_r      <= pwdata[`RBX_CTRL_RUN];
            `RBX_STATUS_OFF: flags_r    <= pwdata[2:0];
            `RBX_INSTR_OFF:  instr_r    <= pwdata[15:0];
            `RBX_BANK_OFF:   bank_r     <= pwdata[3:0];
            `RBX_FILE_OFF:   fileAddr_r <= pwdata[11:0];
            default:         run_r      <= run_r;
         endcase
      end
   end

   // zero wait state slave
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         pcOut    <= `RBX_PC_RST;
         phaseOut <= Q1;
      end else begin
         pcOut    <= pc_r;
         phaseOut <= phase_r;
         pready   <= psel & ~penable;
         pslverr  <= psel & ~penable & ~hit;
         prdata   <= 32'h0000_0000;
         if (psel & ~penable & ~pwrite) begin
            prdata <= rdMux;
         end
      end
   end
endmodule // rbx_exec

// ---- rtl/rbx_defs.vh ----
`ifndef RBX_DEFS_VH
`define RBX_DEFS_VH
// apb register byte offsets
`define RBX_CTRL_OFF     8'h00
`define RBX_STATUS_OFF   8'h04
`define RBX_PC_OFF       8'h08
`define RBX_INSTR_OFF    8'h0C
`define RBX_BANK_OFF     8'h10
`define RBX_FILE_OFF     8'h14
`define RBX_FDATA_OFF    8'h18
// ctrl bits
`define RBX_CTRL_RUN     0
// status fields (flags in bits 2:0)
`define RBX_ST_NEG       0
`define RBX_ST_OVF       1
`define RBX_ST_ZERO      2
`define RBX_ST_BUSY      8
`define RBX_ST_SKIP      9
`define RBX_ST_PHASE     12
// opcodes
`define RBX_OP_SIGN_BR   8'hE7
`define RBX_OP_OVF_BR    8'hE5
`define RBX_OP_ZERO_BR   8'hE1
`define RBX_OP_ALWAYS_BR 5'h1A
`define RBX_OP_SET_BIT   4'h8
`define RBX_OP_BTSS      4'hA
// pc reset value; error data word, not used by the rtl
`define RBX_PC_RST       21'h00_0000
`define RBX_ERR_DATA     32'hDEAD_BEEF
`endif

// ---- rtl/rbx_target.v ----
`timescale 1ns/1ps
// branch target: incremented pc plus twice the signed offset
module rbx_target #(
   parameter PCW = 21
) (
   // operands
   input  wire [PCW-1:0] pcInc,
   input  wire [10:0]    offset,
   input  wire           longForm,
   // result
   output wire [PCW-1:0] target
);
   wire [PCW-1:0] shortExt;
   wire [PCW-1:0] longExt;
   assign shortExt = {{(PCW-9){offset[7]}}, offset[7:0], 1'b0};
   assign longExt  = {{(PCW-12){offset[10]}}, offset[10:0], 1'b0};
   assign target   = pcInc + (longForm ? longExt : shortExt);
endmodule // rbx_target

// ---- tb/rbx_exec_checker.sv ----
`timescale 1ns/1ps
module rbx_exec_checker #(
   parameter PCW = 21
) (
   // clock and reset
   input wire           clk,
   input wire           rst,
   // apb
   input wire           psel,
   input wire           penable,
   input wire [31:0]    prdata,
   input wire           pready,
   input wire           pslverr,
   // core
   input wire [PCW-1:0] pcOut,
   input wire [3:0]     phaseOut
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_PHASE_ONEHOT:
      assert property ($onehot(phaseOut)) else $error("phase not one-hot");
   AST_PHASE_ORDER:
      assert property (phaseOut != $past(phaseOut) |-> phaseOut == {$past(phaseOut[2:0]), $past(phaseOut[3])})
      else $error("phase out of order");
   AST_PC_EVEN:
      assert property (pcOut[0] == 1'b0) else $error("odd program counter");
   AST_PC_HOLD:
      assert property (phaseOut == $past(phaseOut) && $past(phaseOut) == $past(phaseOut, 2) |-> $stable(pcOut))
      else $error("pc moved while core halted");
   AST_READY_SETUP:
      assert property (psel && !penable |=> pready) else $error("no answer after setup");
   AST_READY_ACCESS:
      assert property (pready |-> psel && penable ##1 !pready) else $error("ready outside access");
   AST_ERR_READY:
      assert property (pslverr |-> pready) else $error("error without ready");
   AST_ERR_DATA:
      assert property (pslverr |-> prdata == 32'h0000_0000) else $error("error read data not zero");
endmodule // rbx_exec_checker

bind rbx_exec rbx_exec_checker #(.PCW(PCW)) u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pcOut(pcOut), .phaseOut(phaseOut));

// ---- tb/rbx_testbench.sv ----
`timescale 1ns/1ps
`include "rbx_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
   reg         clk, rst, psel, penable, pwrite, sawT, sawS, errS;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, rd;
   reg  [20:0] p0, tgt;
   reg  [2:0]  fl;
   wire [31:0] prdata;
   wire        pready, pslverr;
   wire [20:0] pcOut;
   wire [3:0]  phaseOut;
   integer     num_errors = 0, checked = 0, cyc = 0, i, v;
   rbx_exec #(.PCW(21)) u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pcOut(pcOut), .phaseOut(phaseOut));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // hang guard, tests need about five hundred and forty cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         num_errors++;
         test_done;
      end
   end
   task test_done;
      begin
         $display("errors %0d checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   // request held until pready is sampled high at a rising edge
   task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
      begin
         psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge clk);
         penable <= 1;
         do @(posedge clk); while (pready !== 1'b1);
         rd = prdata;
         errS = pslverr;
         psel <= 0; penable <= 0;
         @(posedge clk);
      end
   endtask
   // skip-if-set, core stopped after one instruction cycle
   task skipOne(input reg [15:0] ins, input reg exp);
      begin
         apb(1, `RBX_INSTR_OFF, {16'h0, ins});
         apb(1, `RBX_CTRL_OFF, 1);
         apb(1, `RBX_CTRL_OFF, 0);
         repeat (8) @(posedge clk);
         apb(0, `RBX_STATUS_OFF, 0);
         `CHK("skip", exp, rd[`RBX_ST_SKIP])
      end
   endtask
   // one instruction from a halted core; pc checked at the port
   task runOne(input reg [15:0] ins, input reg tk, input reg [20:0] off, input reg br);
      begin
         apb(1, `RBX_STATUS_OFF, {29'h0, fl});
         apb(0, `RBX_PC_OFF, 0);
         p0 = rd[20:0];
         tgt = p0 + 21'd2 + (off << 1);
         apb(1, `RBX_INSTR_OFF, {16'h0, ins});
         apb(1, `RBX_CTRL_OFF, 1);
         sawT = 0; sawS = 0;
         repeat (24) begin
            @(posedge clk);
            if (pcOut === tgt) sawT = 1;
            if (pcOut === p0 + 21'd4) sawS = 1;
         end
         apb(1, `RBX_CTRL_OFF, 0);
         if (br) begin
            `CHK("taken", tk, sawT)
            `CHK("sequential", !tk, sawS)
         end
         apb(0, `RBX_STATUS_OFF, 0);
         `CHK("flags", fl, rd[2:0])
      end
   endtask
   initial begin
      rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; fl = 0;
      repeat (12) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      `CHK("phase", 4'h1, phaseOut)
      `CHK("pc", 21'h00_0000, pcOut)
      apb(0, 8'hFC, 0);
      `CHK("slverr", 1'b1, errS)
      // each conditional opcode, flag clear and set, boundary offsets
      for (i = 0; i < 3; i++) for (v = 0; v < 2; v++) begin
         fl = v << i;
         runOne({(i == 0) ? 8'hE7 : (i == 1) ? 8'hE5 : 8'hE1, v ? 8'h80 : 8'h7F}, v == 0,
            v ? 21'h1F_FF80 : 21'h00_007F, 1);
      end
      fl = 3'h7;
      runOne(16'hD3FF, 1, 21'h00_03FF, 1);
      runOne(16'hD400, 1, 21'h1F_FC00, 1);
      // set-bit keeps other bits, both bank modes
      apb(1, `RBX_BANK_OFF, 5);
      apb(1, `RBX_FILE_OFF, 3);
      apb(1, `RBX_FDATA_OFF, 8'h0A);
      runOne(16'h8E03, 0, 0, 0);
      apb(0, `RBX_FDATA_OFF, 0);
      `CHK("setbit", 32'h0000_008A, rd)
      runOne(16'h8103, 0, 0, 0);
      apb(0, `RBX_FDATA_OFF, 0);
      `CHK("setbank", 32'h0000_008B, rd)
      skipOne(16'hA403, 0);
      skipOne(16'hAE03, 1);
      // pending skip drops the next set-bit word
      runOne(16'h8803, 0, 0, 0);
      apb(0, `RBX_FDATA_OFF, 0);
      `CHK("skipped", 32'h0000_008B, rd)
      test_done;
   end
endmodule // testbench
